// file: core/aics_config.sv
// Converter clock, sample time, input routing and pin mode configuration with APB slave
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "aics_params.svh"

module aics_config #(
    parameter bit SIX_INPUTS = 1'b1
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              converter_module_disable,
    input  wire logic              sample_done,
    input  wire logic [5:0]        pin_level,
    output logic [5:0]             port_read_data,
    output logic [5:0]             pin_is_digital,
    output logic                   conv_clock_source_sel,
    output logic [7:0]             conv_clock_divider,
    output logic                   divider_reserved,
    output logic                   auto_sample_active,
    output logic [4:0]             auto_sample_time,
    output logic                   sample_b_phase,
    output aics_pkg::aics_src_t    ch0_pos_src,
    output logic [2:0]             ch0_pos_input,
    output logic                   ch0_neg_is_input1,
    output logic [2:0]             ch123_pos_valid,
    output logic [2:0]             ch1_pos_input,
    output logic [2:0]             ch2_pos_input,
    output logic [2:0]             ch3_pos_input,
    output logic                   ch123_neg_reserved
);
    import aics_pkg::*;

    typedef struct packed {
        logic [15:0] clk_cfg;
        logic [15:0] ch123;
        logic [15:0] ch0;
        logic [15:0] scan;
        logic [15:0] pcfg;
        logic [15:0] ctrl;
        logic        phase_b;
        logic [2:0]  scan_ptr;
        logic [31:0] rdata;
        logic [5:0]  port_rd;
    } aics_state_t;

    aics_state_t st_q;
    aics_state_t st_d;

    // Next selected input above cur, wrapping to the lowest selected one
    function automatic logic [2:0] aics_next_scan(input logic [5:0] m, input logic [2:0] cur);
        logic [2:0] res;
        logic       found;
        res = cur;
        found = 1'b0;
        for (int i = 1; i <= 6; i++)
        begin
            if (!found && m[(32'(cur) + i) % 6])
            begin
                res = 3'((32'(cur) + i) % 6);
                found = 1'b1;
            end
        end
        return res;
    endfunction : aics_next_scan

    function automatic logic aics_pin_exists(input logic [2:0] idx);
        return idx < (SIX_INPUTS ? `AICS_PINS_LARGE : `AICS_PINS_SMALL);
    endfunction : aics_pin_exists

    logic       access;
    logic [2:0] trig_src;
    logic       alt_en;
    logic       scan_en;
    logic       module_on;
    logic [4:0] pos_sel;
    logic       neg_sel;
    logic       c123_pos;
    logic [1:0] c123_neg;
    logic [5:0] digital;

    assign access    = psel && penable;
    assign trig_src  = st_q.ctrl[2:0];
    assign alt_en    = st_q.ctrl[4];
    assign scan_en   = st_q.ctrl[5];
    assign module_on = st_q.ctrl[6];

    always_comb
    begin
        st_d = st_q;
        st_d.rdata = 32'h0000_0000;
        if (access && pwrite)
        begin
            if (paddr == `AICS_OFF_CLK)
                st_d.clk_cfg = pwdata[15:0] & `AICS_MASK_CLK; // RL19
            else if (paddr == `AICS_OFF_CH123)
                st_d.ch123 = pwdata[15:0] & `AICS_MASK_CH123; // RL19
            else if (paddr == `AICS_OFF_CH0)
                st_d.ch0 = pwdata[15:0] & `AICS_MASK_CH0; // RL19
            else if (paddr == `AICS_OFF_SCAN)
                st_d.scan = pwdata[15:0] & `AICS_MASK_6; // RL12
            else if (paddr == `AICS_OFF_PCFG)
                st_d.pcfg = pwdata[15:0] & `AICS_MASK_6; // RL18
            else if (paddr == `AICS_OFF_CTRL)
                st_d.ctrl = pwdata[15:0] & `AICS_MASK_CTRL;
        end
        if (psel && !penable && !pwrite)
        begin
            if (paddr == `AICS_OFF_CLK)
                st_d.rdata = {16'h0000, st_q.clk_cfg};
            else if (paddr == `AICS_OFF_CH123)
                st_d.rdata = {16'h0000, st_q.ch123};
            else if (paddr == `AICS_OFF_CH0)
                st_d.rdata = {16'h0000, st_q.ch0};
            else if (paddr == `AICS_OFF_SCAN)
                st_d.rdata = {16'h0000, st_q.scan};
            else if (paddr == `AICS_OFF_PCFG)
                st_d.rdata = {16'h0000, st_q.pcfg};
            else if (paddr == `AICS_OFF_CTRL)
                st_d.rdata = {16'h0000, st_q.ctrl};
            else if (paddr == `AICS_OFF_STAT)
                st_d.rdata = {26'h0000000, st_q.scan_ptr, st_q.phase_b, 2'h0};
        end
        // Sample sequencing: alternate A/B and scan pointer advance
        if (!module_on)
        begin
            st_d.phase_b = 1'b0;
        end
        else if (sample_done)
        begin
            st_d.phase_b = alt_en ? !st_q.phase_b : 1'b0; // RL21
            if (scan_en && !st_q.phase_b)
                st_d.scan_ptr = aics_next_scan(st_q.scan[5:0], st_q.scan_ptr); // RL23
        end
        if (!alt_en)
            st_d.phase_b = 1'b0; // RL21
        st_d.port_rd = pin_level & digital; // RL16
        if (sys_rst)
        begin
            st_d = '0; // RL15
        end
    end

    always_ff @(posedge clock)
    begin
        st_q <= st_d;
    end

    // Pin mode: disabled module forces all pins digital, else missing pins stay analog-inert
    always_comb
    begin
        for (int p = 0; p < 6; p++)
        begin
            if (!module_on && converter_module_disable)
                digital[p] = 1'b1; // RL17
            else if (converter_module_disable)
                digital[p] = 1'b1; // RL17
            else if (aics_pin_exists(3'(p)))
                digital[p] = st_q.pcfg[p]; // RL14
            else
                digital[p] = 1'b0; // RL18
        end
    end

    assign pin_is_digital = digital;
    assign port_read_data = st_q.port_rd; // RL16

    // Clock configuration
    assign conv_clock_source_sel = st_q.clk_cfg[`AICS_POS_SRC]; // RL1
    assign conv_clock_divider    = conv_clock_source_sel ? 8'h00 :
        st_q.clk_cfg[`AICS_POS_DIV_HI:`AICS_POS_DIV_LO]; // RL4 RL5
    assign divider_reserved = !conv_clock_source_sel &&
        (st_q.clk_cfg[`AICS_POS_DIV_HI:`AICS_POS_DIV_LO] >= `AICS_DIV_RSV_MIN); // RL4
    assign auto_sample_active = (trig_src == `AICS_TRIG_COUNTER); // RL20
    assign auto_sample_time   = auto_sample_active ?
        st_q.clk_cfg[`AICS_POS_SAMC_HI:`AICS_POS_SAMC_LO] : 5'h00; // RL2 RL3

    assign sample_b_phase = st_q.phase_b;

    // Channel 0 routing
    always_comb
    begin
        pos_sel  = st_q.phase_b ? st_q.ch0[12:8] : st_q.ch0[4:0]; // RL21
        neg_sel  = st_q.phase_b ? st_q.ch0[15] : st_q.ch0[7];
        c123_pos = st_q.phase_b ? st_q.ch123[8] : st_q.ch123[0];
        c123_neg = st_q.phase_b ? st_q.ch123[10:9] : st_q.ch123[2:1];
        ch0_pos_input = 3'h0;
        ch0_pos_src   = AICS_SRC_NONE;
        if (scan_en && !st_q.phase_b)
        begin
            // Scan only visits numbered inputs, never the sensor
            ch0_pos_input = st_q.scan_ptr; // RL22 RL13
            ch0_pos_src   = aics_pin_exists(st_q.scan_ptr) ? AICS_SRC_INPUT
                          : AICS_SRC_LOWREF; // RL11 RL12
        end
        else if (pos_sel <= `AICS_SEL_MAX_IN)
        begin
            ch0_pos_input = pos_sel[2:0]; // RL10
            ch0_pos_src   = aics_pin_exists(pos_sel[2:0]) ? AICS_SRC_INPUT
                          : AICS_SRC_NONE;
        end
        else if (pos_sel == `AICS_SEL_TEMP)
        begin
            ch0_pos_src = AICS_SRC_TEMP; // RL10
        end
        ch0_neg_is_input1 = neg_sel; // RL9
    end

    // Channels 1-3 routing
    always_comb
    begin
        ch123_neg_reserved = c123_neg[1]; // RL6
        if (!c123_pos)
        begin
            ch123_pos_valid = 3'h7;
            ch1_pos_input   = 3'h0;
            ch2_pos_input   = 3'h1;
            ch3_pos_input   = 3'h2;
        end
        else if (SIX_INPUTS)
        begin
            ch123_pos_valid = 3'h7; // RL8
            ch1_pos_input   = 3'h3;
            ch2_pos_input   = 3'h4;
            ch3_pos_input   = 3'h5;
        end
        else
        begin
            ch123_pos_valid = 3'h1; // RL7
            ch1_pos_input   = 3'h3;
            ch2_pos_input   = 3'h0;
            ch3_pos_input   = 3'h0;
        end
    end

    // APB answers with zero wait states
    assign pready  = 1'b1;
    assign prdata  = st_q.rdata;
    assign pslverr = 1'b0;

endmodule : aics_config

// file: common/aics_params.svh
// Register offsets, field positions, reset values and timing counts for the converter input/clock config
// What this block does
// (RL1) Clock source bit: set RC, clear system-derived
// (RL2) Five-bit auto sample time, 0 to 31 periods
// (RL3) Auto sample time used only with counter trigger
// (RL4) Conversion period is Tcy times divider plus one
// (RL5) Divider ignored when RC clock is selected
// (RL6) Channel 1-3 negative selects: 0x is ground
// (RL7) Four-input variant: set routes input 3 only
// (RL8) Six-input variant: set routes inputs 3, 4, 5
// (RL9) Channel 0 negative: set input 1, clear ground
// (RL10) Channel 0 positive: inputs 0-5, sensor, disconnect
// (RL11) Scan mask bit x includes input x
// (RL12) Scan bits writable; missing pin converts low reference
// (RL13) Temperature sensor never enters the scan
// (RL14) Config bit set: digital, read enabled, mux grounded
// (RL15) Pins reset to analog mode
// (RL16) Port read of analog pin returns zero
// (RL17) Module disabled: all shared pins digital
// (RL18) Config bits writable; missing pins ignored
// (RL19) Unimplemented bits read zero, writes ignored
// (RL20) Trigger code 111 is internal counter mode
// (RL21) Alternate sampling swaps A and B selections
// (RL22) Scan drives channel 0 positive during sample A
// (RL23) Scan steps ascending, wraps to lowest selected
`ifndef AICS_PARAMS_SVH
`define AICS_PARAMS_SVH

`define AICS_OFF_CLK        12'h000
`define AICS_OFF_CH123      12'h004
`define AICS_OFF_CH0        12'h008
`define AICS_OFF_SCAN       12'h00C
`define AICS_OFF_PCFG       12'h010
`define AICS_OFF_CTRL       12'h014
`define AICS_OFF_STAT       12'h018

`define AICS_MASK_CLK       16'h9FFF
`define AICS_MASK_CH123     16'h0707
`define AICS_MASK_CH0       16'h9F9F
`define AICS_MASK_6         16'h003F
`define AICS_MASK_CTRL      16'h00F7
`define AICS_RST_VAL        16'h0000

`define AICS_POS_SRC        15
`define AICS_POS_SAMC_HI    12
`define AICS_POS_SAMC_LO    8
`define AICS_POS_DIV_HI     7
`define AICS_POS_DIV_LO     0
`define AICS_DIV_RSV_MIN    8'h40

`define AICS_TRIG_COUNTER   3'h7
`define AICS_SEL_TEMP       5'h0D
`define AICS_SEL_NONE       5'h0E
`define AICS_SEL_MAX_IN     5'h05
`define AICS_PINS_SMALL     3'h4
`define AICS_PINS_LARGE     3'h6
`define AICS_CLK_NS         4
`endif

// file: common/aics_pkg.sv
// Types shared by the converter input and clock configuration block
package aics_pkg;
    typedef enum logic [1:0] {
        AICS_SRC_INPUT = 2'h0,
        AICS_SRC_TEMP  = 2'h1,
        AICS_SRC_NONE  = 2'h2,
        AICS_SRC_LOWREF = 2'h3
    } aics_src_t;
endpackage : aics_pkg

// file: verif/aics_config_assertions.sv
// Port-level assertions for the converter configuration block
module aics_config_chk #(
    parameter bit SIX_INPUTS = 1'b1
) (
    input wire logic                clock,
    input wire logic                sys_rst,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [31:0]         prdata,
    input wire logic                converter_module_disable,
    input wire logic [5:0]          pin_level,
    input wire logic [5:0]          port_read_data,
    input wire logic [5:0]          pin_is_digital,
    input wire logic                conv_clock_source_sel,
    input wire logic [7:0]          conv_clock_divider,
    input wire logic                divider_reserved,
    input wire logic                auto_sample_active,
    input wire logic [4:0]          auto_sample_time,
    input wire aics_pkg::aics_src_t ch0_pos_src,
    input wire logic [2:0]          ch0_pos_input,
    input wire logic [2:0]          ch123_pos_valid
);
    import aics_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_rc_div_zero: assert property (conv_clock_source_sel |-> conv_clock_divider == 8'h00)
        else $error("divider not forced with rc clock");
    a_div_rsv_flag: assert property (divider_reserved ==
        (!conv_clock_source_sel && conv_clock_divider >= 8'h40)) else $error("reserved flag");
    a_samc_gate: assert property (!auto_sample_active |-> auto_sample_time == 5'h00)
        else $error("sample time not gated");
    a_pin_disable: assert property (converter_module_disable |-> pin_is_digital == 6'h3F)
        else $error("disabled module left analog pins");
    a_port_read: assert property (!$past(sys_rst) |->
        port_read_data == ($past(pin_level) & $past(pin_is_digital))) else $error("port read");
    a_pins_reset: assert property ($fell(sys_rst) && !converter_module_disable |->
        pin_is_digital == 6'h00) else $error("pins not analog after reset");
    a_apb_answer: assert property (pready && !pslverr) else $error("apb answer");
    a_rdata_idle: assert property (!($past(psel) && !$past(penable)) |-> prdata == 32'h0)
        else $error("read data not cleared");
    a_six_valid: assert property (SIX_INPUTS |-> ch123_pos_valid == 3'h7)
        else $error("channel 1-3 not connected");
    a_ch0_range: assert property (ch0_pos_src == AICS_SRC_INPUT |-> ch0_pos_input <= 3'h5)
        else $error("channel 0 input out of range");
    cover property (conv_clock_source_sel);
    cover property (divider_reserved);
    cover property (converter_module_disable ##1 !converter_module_disable);
    cover property (ch0_pos_src == AICS_SRC_TEMP);
endmodule : aics_config_chk

bind aics_config aics_config_chk #(.SIX_INPUTS(SIX_INPUTS)) u_chk (.*);

// file: verif/aics_config_bench.sv
// Self-checking bench for the converter configuration block
`include "aics_params.svh"
module aics_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import aics_pkg::*;
    logic clock, sys_rst, psel, penable, pwrite, converter_module_disable, sample_done;
    logic pready, pslverr, conv_clock_source_sel, divider_reserved, auto_sample_active;
    logic sample_b_phase, ch0_neg_is_input1, ch123_neg_reserved;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, c, h, z, t, chv;
    logic [5:0]  pin_level, port_read_data, pin_is_digital, pd;
    logic [7:0]  conv_clock_divider;
    logic [4:0]  auto_sample_time;
    logic [2:0]  ch0_pos_input, ch123_pos_valid, ch1_pos_input, ch2_pos_input, ch3_pos_input;
    aics_src_t   ch0_pos_src;
    int          err_count, samples_checked, cycles;
    int          regs [7];
    int          masks [7] = '{`AICS_MASK_CLK, `AICS_MASK_CH123, `AICS_MASK_CH0,
                               `AICS_MASK_6, `AICS_MASK_6, `AICS_MASK_CTRL, 0};
    logic [4:0]  codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0D, 5'h0E};
    logic [2:0]  scan_seq [3] = '{3'h0, 3'h2, 3'h5};

    aics_config #(.SIX_INPUTS(1'b1)) uut (.*);

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic complete_run();
        if (err_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (w && a < 12'h01C)
            regs[a >> 2] = d & masks[a >> 2];
    endtask : apb

    task automatic rchk(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        check(rd, a < 12'h01C ? regs[a >> 2] : 32'h0);
    endtask : rchk

    task automatic pulse();
        sample_done <= 1'b1;
        @(posedge clock);
        sample_done <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : pulse

    task automatic chk_ch(input bit b);
        logic [4:0] s;
        s = b ? z[12:8] : z[4:0];
        check(ch0_neg_is_input1, b ? z[15] : z[7]);
        check(ch0_pos_src, s <= 5'h05 ? AICS_SRC_INPUT :
              s == 5'h0D ? AICS_SRC_TEMP : AICS_SRC_NONE);
        if (s <= 5'h05)
            check(ch0_pos_input, s[2:0]);
        check({ch1_pos_input, ch2_pos_input, ch3_pos_input},
              h[b ? 8 : 0] ? 9'h0E5 : 9'h00A);
        check(ch123_neg_reserved, h[b ? 10 : 2]);
    endtask : chk_ch

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {converter_module_disable, sample_done, pin_level} = '0;
        sys_rst = 1'b1;
        void'($urandom(32'h43e05d49));
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        check(pin_is_digital, 6'h00);
        for (int j = 0; j < 9; j++) rchk(12'(j * 4));
        apb(1'b1, 12'h018, 32'hFFFFFFFF);
        apb(1'b1, 12'h01C, 32'hFFFFFFFF);
        rchk(12'h018);
        rchk(12'h01C);
        for (int i = 0; i < 24; i++)
        begin
            chv = ($urandom & 32'hFFFFE0E0) | codes[$urandom % 8] | (32'(codes[$urandom % 8]) << 8);
            for (int j = 0; j < 6; j++)
                apb(1'b1, 12'(j * 4), j == 2 ? chv : j == 5 ? ($urandom & 32'hFFFFFFCF) : $urandom);
            pin_level <= $urandom;
            converter_module_disable <= $urandom;
            for (int j = 0; j < 8; j++) rchk(12'(j * 4));
            c = regs[0];
            h = regs[1];
            z = regs[2];
            t = regs[5];
            pd = converter_module_disable ? 6'h3F : regs[4][5:0];
            check(conv_clock_source_sel, c[15]);
            check(conv_clock_divider, c[15] ? 8'h00 : c[7:0]);
            check(divider_reserved, !c[15] && c[7:0] >= 8'h40);
            check(auto_sample_time, t[2:0] == 3'h7 ? c[12:8] : 5'h00);
            check(pin_is_digital, pd);
            check(port_read_data, pin_level & pd);
            chk_ch(1'b0);
        end
        apb(1'b1, 12'h014, 32'h50);
        for (int k = 0; k < 4; k++)
        begin
            check(sample_b_phase, k % 2);
            chk_ch(k % 2);
            pulse();
        end
        apb(1'b1, 12'h014, 32'h60);
        apb(1'b1, 12'h00C, 32'h25);
        for (int k = 0; k < 7; k++)
        begin
            check(ch0_pos_src, AICS_SRC_INPUT);
            check(ch0_pos_input, scan_seq[k % 3]);
            pulse();
        end
        complete_run();
    end
endmodule : aics_config_bench
